/* core/park_seq_pkg.sv */
// Shared constants and carrier types for the power, reset and park sequencer.
package park_seq_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 125000000;
    localparam int NORMAL_PARK_MS = 20;
    localparam int FAST_PARK_US = 32;
    localparam int NORMAL_PARK_CYCLES = NORMAL_PARK_MS * (CLK_HZ / 1000);
    localparam int FAST_PARK_CYCLES = FAST_PARK_US * (CLK_HZ / 1000000);
    localparam int PLL_LOCK_CYCLES = 64;
    localparam int CNT_W = 32;
    localparam int GPIO_W = 20;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic INIT_FLAG_RST = 1'b1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET,
        ST_PLL_LOCK,
        ST_FLASH_LOAD,
        ST_READY,
        ST_NORMAL_PARK,
        ST_FAST_PARK,
        ST_PARKED
    } seq_state_t;

    typedef struct packed {
        logic flash_serial_clock;
        logic flash_serial_out;
        logic flash_select0_n;
        logic flash_select1_n;
        logic [GPIO_W-1:0] gpio;
    } flash_gpio_t;

    typedef struct packed {
        logic illum_select_0;
        logic illum_select_1;
        logic mirror_array_enable_rst_n;
    } mirror_ctl_t;

endpackage

/* core/sync2.sv */
// Two flip-flop synchroniser for one level.
`timescale 1ns/100ps
module sync2 #(
    parameter logic RESET_VALUE = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Level
    input wire logic async_in,
    output logic sync_out
);
    logic meta;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* core/power_reset_park_sequencer.sv */
// Power-up, initialisation and mirror park sequencer with reset pin gating.
`timescale 1ns/100ps

// Functional notes
// - Core power lost with host I/O powered: host-domain outputs go hi-Z.
// - All outputs inactive during reset; active after release.
// - Flash clock, data, both selects and GPIO 19..0 tri-stated in reset.
// - Illumination selects and mirror enable driven low in reset if powered.
// - After release, lock PLL first, then load configuration from flash.
// - Host init flag driven high right after reset release.
// - Host init flag driven low when auto-initialisation completes.
// - Mirror parking completes within 20 ms of projection request falling.
// - Fast-park request low starts a fast park immediately.
// - Projection request high powers up; low powers down to minimum.
module power_reset_park_sequencer #(
    parameter int NORMAL_PARK_CYCLES = park_seq_pkg::NORMAL_PARK_CYCLES,
    parameter int FAST_PARK_CYCLES = park_seq_pkg::FAST_PARK_CYCLES,
    parameter int PLL_LOCK_CYCLES = park_seq_pkg::PLL_LOCK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Pins from power manager and host
    input wire logic system_reset_n,
    input wire logic fast_park_request_n,
    input wire logic projection_on_request,
    input wire logic core_power_good,
    input wire logic host_io_rail_good,
    // Internal status from the flash loader and mirror logic
    input wire logic flash_load_done,
    input wire logic park_done,
    // Functional values from the internal logic
    input wire park_seq_pkg::flash_gpio_t func_flash_gpio,
    input wire park_seq_pkg::flash_gpio_t func_flash_gpio_oe,
    input wire park_seq_pkg::mirror_ctl_t func_mirror,
    // Pads
    output park_seq_pkg::flash_gpio_t pad_flash_gpio,
    output park_seq_pkg::flash_gpio_t pad_flash_gpio_oe,
    output park_seq_pkg::mirror_ctl_t pad_mirror,
    output logic pad_mirror_oe,
    output logic host_init_flag,
    output logic host_init_flag_oe,
    // Status towards the internal logic
    output logic flash_load_start,
    output logic park_normal_active,
    output logic park_fast_active,
    output logic display_enable,
    output park_seq_pkg::seq_state_t seq_state
);
    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NORMAL_PARK_CYCLES < 1 || FAST_PARK_CYCLES < 1 ||
        PLL_LOCK_CYCLES < 1) begin
        $error("cycle counts must be at least one");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic rst_n_s;
    logic park_n_s;
    logic proj_s;
    logic core_pg_s;
    logic io_pg_s;
    logic in_reset;

    sync2 #(.RESET_VALUE(1'b0)) u_sync_rst (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(system_reset_n),
        .sync_out(rst_n_s)
    );
    sync2 #(.RESET_VALUE(1'b0)) u_sync_park (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(fast_park_request_n),
        .sync_out(park_n_s)
    );
    sync2 #(.RESET_VALUE(1'b0)) u_sync_proj (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(projection_on_request),
        .sync_out(proj_s)
    );
    sync2 #(.RESET_VALUE(1'b0)) u_sync_cpg (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(core_power_good),
        .sync_out(core_pg_s)
    );
    sync2 #(.RESET_VALUE(1'b0)) u_sync_iopg (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(host_io_rail_good),
        .sync_out(io_pg_s)
    );

    // Reset low gates the pads directly; release passes the synchroniser.
    assign in_reset = !system_reset_n || !rst_n_s;

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    typedef struct packed {
        park_seq_pkg::seq_state_t st;
        logic [park_seq_pkg::CNT_W-1:0] cnt;
        logic init_flag;
        logic load_start;
    } seq_t;

    seq_t cur;
    seq_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.load_start = 1'b0;
        if (!rst_n_s) begin
            next_cur.st = park_seq_pkg::ST_RESET;
            next_cur.cnt = '0;
            next_cur.init_flag = park_seq_pkg::INIT_FLAG_RST;
        end else if (!park_n_s && cur.st != park_seq_pkg::ST_FAST_PARK &&
                     cur.st != park_seq_pkg::ST_PARKED) begin
            next_cur.st = park_seq_pkg::ST_FAST_PARK;
            next_cur.cnt = '0;
        end else begin
            case (cur.st)
                park_seq_pkg::ST_RESET: begin
                    next_cur.st = park_seq_pkg::ST_PLL_LOCK;
                    next_cur.cnt = '0;
                    next_cur.init_flag = 1'b1;
                end
                park_seq_pkg::ST_PLL_LOCK: begin
                    if (cur.cnt >=
                        park_seq_pkg::CNT_W'(PLL_LOCK_CYCLES - 1)) begin
                        next_cur.st = park_seq_pkg::ST_FLASH_LOAD;
                        next_cur.load_start = 1'b1;
                    end else begin
                        next_cur.cnt = cur.cnt + 1'b1;
                    end
                end
                park_seq_pkg::ST_FLASH_LOAD: begin
                    if (flash_load_done) begin
                        next_cur.st = park_seq_pkg::ST_READY;
                        next_cur.init_flag = 1'b0;
                    end
                end
                park_seq_pkg::ST_READY: begin
                    if (!proj_s) begin
                        next_cur.st = park_seq_pkg::ST_NORMAL_PARK;
                        next_cur.cnt = '0;
                    end
                end
                park_seq_pkg::ST_NORMAL_PARK: begin
                    // Parking is forced complete at the 20 ms bound.
                    if (park_done || cur.cnt >=
                        park_seq_pkg::CNT_W'(NORMAL_PARK_CYCLES - 1)) begin
                        next_cur.st = park_seq_pkg::ST_PARKED;
                    end else begin
                        next_cur.cnt = cur.cnt + 1'b1;
                    end
                end
                park_seq_pkg::ST_FAST_PARK: begin
                    if (park_done || cur.cnt >=
                        park_seq_pkg::CNT_W'(FAST_PARK_CYCLES - 1)) begin
                        next_cur.st = park_seq_pkg::ST_PARKED;
                    end else begin
                        next_cur.cnt = cur.cnt + 1'b1;
                    end
                end
                park_seq_pkg::ST_PARKED: begin
                    if (proj_s && park_n_s) begin
                        next_cur.st = park_seq_pkg::ST_READY;
                    end
                end
                default: begin
                    next_cur.st = park_seq_pkg::ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur.st <= park_seq_pkg::ST_RESET;
            cur.cnt <= '0;
            cur.init_flag <= park_seq_pkg::INIT_FLAG_RST;
            cur.load_start <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // Pad gating
    // ------------------------------------------------------------------
    logic core_ok;
    assign core_ok = core_pg_s;

    always_comb begin
        pad_flash_gpio = func_flash_gpio;
        pad_flash_gpio_oe = func_flash_gpio_oe;
        pad_mirror = func_mirror;
        pad_mirror_oe = 1'b1;
        host_init_flag = cur.init_flag;
        host_init_flag_oe = 1'b1;
        if (in_reset) begin
            pad_flash_gpio = '0;
            pad_flash_gpio_oe = '0;
            pad_mirror = '0;
            pad_mirror_oe = io_pg_s;
            host_init_flag = 1'b1;
            host_init_flag_oe = 1'b0;
        end
        if (!core_ok) begin
            pad_flash_gpio_oe = '0;
            pad_mirror_oe = 1'b0;
            host_init_flag_oe = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------
    assign flash_load_start = cur.load_start;
    assign park_normal_active = cur.st == park_seq_pkg::ST_NORMAL_PARK;
    assign park_fast_active = cur.st == park_seq_pkg::ST_FAST_PARK;
    assign display_enable = cur.st == park_seq_pkg::ST_READY;
    assign seq_state = cur.st;
endmodule

/* sim/park_seq_assertions.sv */
// Port checker for the power, reset and park sequencer.
`timescale 1ns/100ps
module park_seq_assertions #(
    parameter int NORMAL_PARK_CYCLES = 50
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Pins and outputs watched
    input wire logic system_reset_n,
    input wire logic fast_park_request_n,
    input wire logic core_power_good,
    input wire park_seq_pkg::flash_gpio_t pad_flash_gpio_oe,
    input wire park_seq_pkg::mirror_ctl_t pad_mirror,
    input wire logic pad_mirror_oe,
    input wire logic host_init_flag,
    input wire logic host_init_flag_oe,
    input wire logic park_fast_active,
    input wire park_seq_pkg::seq_state_t seq_state
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [31:0] park_cnt;
    always_ff @(posedge core_clk) begin
        if (rst || seq_state != park_seq_pkg::ST_NORMAL_PARK)
            park_cnt <= '0;
        else
            park_cnt <= park_cnt + 32'h1;
    end
    flash_tristate_a: assert property (
        !system_reset_n |-> pad_flash_gpio_oe == '0)
        else $error("flash and gpio pads driven in reset");
    mirror_low_a: assert property (
        !system_reset_n |-> pad_mirror == '0)
        else $error("mirror pads not low in reset");
    reset_return_a: assert property (
        !system_reset_n |-> ##[1:4] seq_state == park_seq_pkg::ST_RESET)
        else $error("state did not return to reset");
    flag_busy_a: assert property (
        seq_state inside {park_seq_pkg::ST_PLL_LOCK,
            park_seq_pkg::ST_FLASH_LOAD} |-> host_init_flag)
        else $error("init flag low during initialisation");
    flag_done_a: assert property (
        seq_state == park_seq_pkg::ST_READY
            && $past(seq_state) == park_seq_pkg::ST_READY
            |-> !host_init_flag)
        else $error("init flag high when ready");
    lock_then_load_a: assert property (
        seq_state == park_seq_pkg::ST_FLASH_LOAD
            && $past(seq_state) != park_seq_pkg::ST_FLASH_LOAD
            |-> $past(seq_state) == park_seq_pkg::ST_PLL_LOCK)
        else $error("flash load entered without lock");
    fast_park_a: assert property (
        $fell(fast_park_request_n) && seq_state == park_seq_pkg::ST_READY
            |-> ##[1:4] park_fast_active)
        else $error("fast park did not start");
    park_bound_a: assert property (
        park_cnt <= 32'(NORMAL_PARK_CYCLES))
        else $error("normal park too long");
    core_loss_a: assert property (
        !core_power_good [*4] |-> pad_flash_gpio_oe == '0
            && !pad_mirror_oe && !host_init_flag_oe)
        else $error("pads driven without core power");
endmodule

/* sim/power_host_model.sv */
// Power manager and host model that drives the sequencer pins.
`timescale 1ns/100ps
module power_host_model #(
    parameter int RESET_HOLD = 30
) (
    // Clock
    input wire logic core_clk,
    // Commands from the bench
    input wire logic power_on,
    input wire logic fault,
    input wire logic proj_cmd,
    input wire logic core_fail,
    // Pins
    output logic system_reset_n,
    output logic fast_park_request_n,
    output logic projection_on_request,
    output logic core_power_good,
    output logic host_io_rail_good
);
    int hold = 0;
    initial begin
        system_reset_n = 1'b0;
        fast_park_request_n = 1'b0;
        projection_on_request = 1'b0;
        core_power_good = 1'b0;
        host_io_rail_good = 1'b0;
    end
    always @(posedge core_clk) begin
        core_power_good <= power_on && !core_fail;
        host_io_rail_good <= power_on;
        fast_park_request_n <= power_on && !fault;
        projection_on_request <= proj_cmd;
        if (!power_on)
            hold <= 0;
        else if (fast_park_request_n && hold < RESET_HOLD)
            hold <= hold + 1;
        // Reset drops only with power, so it stays released in a park.
        system_reset_n <= power_on && hold >= RESET_HOLD;
    end
endmodule

/* sim/power_reset_park_sequencer_bench.sv */
// Testbench for the power, reset and park sequencer.
`timescale 1ns/100ps
module power_reset_park_sequencer_bench;
    localparam int NPC = 50;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic power_on = 1'b0;
    logic fault = 1'b0;
    logic proj_cmd = 1'b1;
    logic core_fail = 1'b0;
    logic display_enable;
    logic flash_load_done = 1'b0;
    logic park_done = 1'b0;
    park_seq_pkg::flash_gpio_t func_io = 24'h5a5c3f;
    park_seq_pkg::flash_gpio_t func_oe = 24'hc3a5f1;
    park_seq_pkg::mirror_ctl_t func_mirror = 3'h5;
    wire logic system_reset_n;
    wire logic fast_park_request_n;
    wire logic projection_on_request;
    wire logic core_power_good;
    wire logic host_io_rail_good;
    park_seq_pkg::flash_gpio_t pad_flash_gpio;
    park_seq_pkg::flash_gpio_t pad_flash_gpio_oe;
    park_seq_pkg::mirror_ctl_t pad_mirror;
    logic pad_mirror_oe;
    logic host_init_flag;
    logic host_init_flag_oe;
    logic flash_load_start;
    logic park_normal_active;
    logic park_fast_active;
    park_seq_pkg::seq_state_t seq_state;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int used;
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    power_host_model model (.core_clk, .power_on, .fault, .proj_cmd, .core_fail,
        .system_reset_n, .fast_park_request_n, .projection_on_request,
        .core_power_good, .host_io_rail_good);
    power_reset_park_sequencer #(.NORMAL_PARK_CYCLES(NPC),
        .FAST_PARK_CYCLES(20), .PLL_LOCK_CYCLES(4)) dut (.core_clk, .rst,
        .system_reset_n, .fast_park_request_n, .projection_on_request,
        .core_power_good, .host_io_rail_good, .flash_load_done, .park_done,
        .func_flash_gpio(func_io), .func_flash_gpio_oe(func_oe), .func_mirror,
        .pad_flash_gpio, .pad_flash_gpio_oe, .pad_mirror, .pad_mirror_oe,
        .host_init_flag, .host_init_flag_oe, .flash_load_start,
        .park_normal_active, .park_fast_active, .display_enable,
        .seq_state);
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(string what, logic [23:0] exp, logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_state(park_seq_pkg::seq_state_t s, int lim);
        for (used = 0; seq_state !== s && used < lim; used++)
            tick(1);
        check("state", 24'(s), 24'(seq_state));
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        power_on <= 1'b1;
        tick(10);
        check("pad oe", 24'h0, pad_flash_gpio_oe);
        check("mirror", 24'h0, pad_mirror);
        check("flag oe", 24'h0, host_init_flag_oe);
        check("pad", 24'h0, pad_flash_gpio);
        check("mirror oe", 24'h1, 24'(pad_mirror_oe));
        wait_state(park_seq_pkg::ST_PLL_LOCK, 60);
        check("flag", 24'h1, host_init_flag);
        for (used = 0; flash_load_start !== 1'b1 && used < 20; used++)
            tick(1);
        check("load start", 24'h1, flash_load_start);
        wait_state(park_seq_pkg::ST_FLASH_LOAD, 0);
        @(posedge core_clk) flash_load_done <= 1'b1;
        @(posedge core_clk) flash_load_done <= 1'b0;
        wait_state(park_seq_pkg::ST_READY, 10);
        tick(1);
        check("flag", 24'h0, host_init_flag);
        check("pad oe", 24'(func_oe), pad_flash_gpio_oe);
        check("mirror", 24'(func_mirror), pad_mirror);
        check("pad", 24'(func_io), pad_flash_gpio);
        check("mirror oe", 24'h1, 24'(pad_mirror_oe));
        check("flag oe", 24'h1, 24'(host_init_flag_oe));
        check("display", 24'h1, 24'(display_enable));
        @(posedge core_clk) core_fail <= 1'b1;
        tick(4);
        check("pad oe", 24'h0, pad_flash_gpio_oe);
        check("mirror oe", 24'h0, 24'(pad_mirror_oe));
        check("flag oe", 24'h0, 24'(host_init_flag_oe));
        wait_state(park_seq_pkg::ST_READY, 0);
        @(posedge core_clk) core_fail <= 1'b0;
        tick(4);
        check("pad oe", 24'(func_oe), pad_flash_gpio_oe);
        @(posedge core_clk) proj_cmd <= 1'b0;
        wait_state(park_seq_pkg::ST_NORMAL_PARK, 8);
        check("normal", 24'h1, park_normal_active);
        check("display", 24'h0, 24'(display_enable));
        wait_state(park_seq_pkg::ST_PARKED, NPC + 8);
        check("park time", 24'h1, 24'(used <= NPC + 1));
        @(posedge core_clk) proj_cmd <= 1'b1;
        wait_state(park_seq_pkg::ST_READY, 10);
        @(posedge core_clk) fault <= 1'b1;
        wait_state(park_seq_pkg::ST_FAST_PARK, 6);
        check("fast", 24'h1, park_fast_active);
        @(posedge core_clk) park_done <= 1'b1;
        @(posedge core_clk) park_done <= 1'b0;
        wait_state(park_seq_pkg::ST_PARKED, 4);
        tick(5);
        wait_state(park_seq_pkg::ST_PARKED, 0);
        @(posedge core_clk) power_on <= 1'b0;
        tick(8);
        check("pad oe", 24'h0, pad_flash_gpio_oe);
        check("flag oe", 24'h0, host_init_flag_oe);
        check("flag", 24'h1, 24'(host_init_flag));
        check("mirror oe", 24'h0, 24'(pad_mirror_oe));
        wait_state(park_seq_pkg::ST_RESET, 8);
        finish_test();
    end
endmodule
bind power_reset_park_sequencer park_seq_assertions #(
    .NORMAL_PARK_CYCLES(NORMAL_PARK_CYCLES)) chk (.core_clk, .rst,
    .system_reset_n, .fast_park_request_n, .core_power_good,
    .pad_flash_gpio_oe, .pad_mirror, .pad_mirror_oe, .host_init_flag,
    .host_init_flag_oe, .park_fast_active, .seq_state);
